// [hdl/thermal_map_pkg.sv]
package thermal_map_pkg;

   // ------------------------------------------------------------------
   // Register bus geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_LINEAR_ENABLE = 8'h00;
   localparam logic [7:0] OFS_STEP_SELECT   = 8'h04;
   localparam logic [7:0] OFS_SCALE_INT     = 8'h08;
   localparam logic [7:0] OFS_NUMERATOR     = 8'h0c;
   localparam logic [7:0] OFS_ADDITIVE      = 8'h10;
   localparam logic [7:0] OFS_OFFSET_FLOAT  = 8'h14;
   localparam logic [7:0] OFS_OFFSET_SIGNED = 8'h18;
   localparam logic [7:0] OFS_REFLECT_K     = 8'h1c;
   localparam logic [7:0] OFS_EMISSIVITY    = 8'h20;
   localparam logic [7:0] OFS_WINDOW_PASS   = 8'h24;
   localparam logic [7:0] OFS_WINDOW_K      = 8'h28;
   localparam logic [7:0] OFS_AIR_PASS      = 8'h2c;
   localparam logic [7:0] OFS_AIR_K         = 8'h30;
   localparam logic [7:0] OFS_COMMAND       = 8'h34;

   // ------------------------------------------------------------------
   // Setting indices and field positions
   // ------------------------------------------------------------------
   localparam int GEN_N     = 8;
   localparam int GEN_LIN   = 0;
   localparam int GEN_STEP  = 1;
   localparam int GEN_REFL  = 2;
   localparam int GEN_EMIS  = 3;
   localparam int GEN_WPASS = 4;
   localparam int GEN_WK    = 5;
   localparam int GEN_APASS = 6;
   localparam int GEN_AK    = 7;
   localparam int PLK_N     = 5;
   localparam int PLK_SCALE = 0;
   localparam int PLK_NUM   = 1;
   localparam int PLK_ADD   = 2;
   localparam int PLK_OFLT  = 3;
   localparam int PLK_OSGN  = 4;
   localparam int GAIN_N    = 2;
   localparam int CMD_SAVE_BIT    = 0;
   localparam int CMD_RESTORE_BIT = 1;
   localparam int STAT_GAIN_BIT   = 0;
   localparam int STAT_SAVED_BIT  = 1;
   localparam int FLOAT_SIGN_BIT  = 31;

   // ------------------------------------------------------------------
   // Reset values and arithmetic constants
   // ------------------------------------------------------------------
   localparam logic [15:0] UNITY_Q15 = 16'h8000;
   localparam logic [31:0] GEN_RESET [GEN_N] = '{
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_8000,
      32'h0000_8000, 32'h0000_0000, 32'h0000_8000, 32'h0000_0000};
   localparam logic [31:0] PLK_RESET [GAIN_N][PLK_N] = '{
      '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
      '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000}};
   localparam int          PIX_W       = 14;
   localparam logic [13:0] PIX_MAX     = 14'h3fff;
   localparam logic [15:0] DIV10_MUL   = 16'hcccd;
   localparam int          DIV10_SHIFT = 19;
   localparam logic [16:0] KELVIN_MAX  = 17'h0ffff;

endpackage

// [hdl/object_correct.sv]
`timescale 1ns/1ps
module object_correct
   import thermal_map_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        enable,
   input  wire logic        in_valid,
   input  wire logic [15:0] in_kelvin,
   input  wire logic [13:0] in_signal,
   input  wire logic [15:0] reflect_k,
   input  wire logic [15:0] emissivity,
   input  wire logic [15:0] window_pass,
   input  wire logic [15:0] window_k,
   input  wire logic [15:0] air_pass,
   input  wire logic [15:0] air_k,
   output logic             out_valid_q,
   output logic      [16:0] out_kelvin_q,
   output logic      [13:0] out_signal_q
);

   // ------------------------------------------------------------------
   // First-order scene correction
   // ------------------------------------------------------------------

   // Each factor short of unity pulls the reading away from its source
   // temperature; unity factors make every term vanish.
   function automatic logic signed [17:0] term(input logic [15:0] factor,
                                               input logic [15:0] t,
                                               input logic [15:0] src);
      logic signed [16:0] loss;
      logic signed [16:0] diff;
      logic signed [33:0] prod;
      loss = 17'(signed'({1'b0, UNITY_Q15})) - 17'(signed'({1'b0, factor}));
      diff = 17'(signed'({1'b0, t})) - 17'(signed'({1'b0, src}));
      prod = loss * diff;
      return 18'(prod >>> 15);
   endfunction

   logic        valid_d;
   logic [16:0] kelvin_d;
   logic [13:0] signal_d;

   // Corrections only touch the stream in linear mode.
   always_comb begin
      logic signed [19:0] sum;
      sum = 20'(signed'({1'b0, in_kelvin}));
      if (enable) begin
         sum = sum + 20'(term(emissivity, in_kelvin, reflect_k))
                   + 20'(term(window_pass, in_kelvin, window_k))
                   + 20'(term(air_pass, in_kelvin, air_k));
      end
      valid_d  = in_valid;
      signal_d = in_signal;
      if (sum < 0) begin
         kelvin_d = 17'h00000;
      end else if (sum > 20'(signed'({3'b000, KELVIN_MAX}))) begin
         kelvin_d = KELVIN_MAX;
      end else begin
         kelvin_d = 17'(sum);
      end
   end

   // One pipeline stage; the product chain would not close timing unbroken.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         out_valid_q  <= 1'b0;
         out_kelvin_q <= 17'h00000;
         out_signal_q <= 14'h0000;
      end else begin
         out_valid_q  <= valid_d;
         out_kelvin_q <= kelvin_d;
         out_signal_q <= signal_d;
      end
   end

endmodule

// [hdl/thermal_pixel_map.sv]
// Functional notes
// - Optional 14-bit temperature-linear pixel output.
// - Linear output follows enable setting one/zero.
// - Step select: 0 gives 0.4 K, 1 gives 0.04 K.
// - Pixel value times step equals kelvin temperature.
// - Off mode passes signal; constants kept per gain.
// - Integer scale, float constants, clamped and signed offsets.
// - Constants reload when gain mode switches.
// - Host writes signed offset; device stores it and reads it back.
// - Save command stores all settings as defaults.
// - Object parameters act only in linear mode.
// - Six object parameters; emissivity, window, air pass default unity.
// - Object parameter defaults leave conversion unchanged.
`timescale 1ns/1ps
module thermal_pixel_map
   import thermal_map_pkg::*;
(
   input  wire logic                                sys_clk,
   input  wire logic                                resetn,
   input  wire logic [thermal_map_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [thermal_map_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                                reg_write,
   input  wire logic                                reg_read,
   output logic      [thermal_map_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic                                gain_high,
   input  wire logic                                pix_valid,
   input  wire logic [13:0]                         pix_signal,
   input  wire logic [15:0]                         pix_kelvin,
   output logic                                     pix_out_valid,
   output logic      [15:0]                         pix_out,
   output logic                                     pix_out_linear
);

   import thermal_map_pkg::*;

   // ------------------------------------------------------------------
   // Block overview
   // ------------------------------------------------------------------
   // Settings live in three groups: the general settings, one bank of
   // conversion constants per gain mode, and a saved copy of both.
   // The pixel path is two stages deep: object correction first, then
   // step scaling and the choice between linear and signal output.
   // Pixels are never stalled, so a setting written while pixels flow
   // reaches the next pixel to pass the stage that reads it.

   // ------------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------------

   // Index of a general setting, or -1 when the address holds none.
   // The chain is ordered by offset; no two settings share an offset.
   function automatic int gen_sel(input logic [ADDR_W-1:0] a);
      if (a == OFS_LINEAR_ENABLE) begin
         return GEN_LIN;
      end else if (a == OFS_STEP_SELECT) begin
         return GEN_STEP;
      end else if (a == OFS_REFLECT_K) begin
         return GEN_REFL;
      end else if (a == OFS_EMISSIVITY) begin
         return GEN_EMIS;
      end else if (a == OFS_WINDOW_PASS) begin
         return GEN_WPASS;
      end else if (a == OFS_WINDOW_K) begin
         return GEN_WK;
      end else if (a == OFS_AIR_PASS) begin
         return GEN_APASS;
      end else if (a == OFS_AIR_K) begin
         return GEN_AK;
      end else begin
         return -1;
      end
   endfunction

   // Index of a conversion constant, or -1 when the address holds none.
   // These five constants are banked; the general settings are not.
   function automatic int plk_sel(input logic [ADDR_W-1:0] a);
      if (a == OFS_SCALE_INT) begin
         return PLK_SCALE;
      end else if (a == OFS_NUMERATOR) begin
         return PLK_NUM;
      end else if (a == OFS_ADDITIVE) begin
         return PLK_ADD;
      end else if (a == OFS_OFFSET_FLOAT) begin
         return PLK_OFLT;
      end else if (a == OFS_OFFSET_SIGNED) begin
         return PLK_OSGN;
      end else begin
         return -1;
      end
   endfunction

   // Width of the stored field; the mode bits and the object parameters
   // are narrower than the bus and their upper bits read as zero.
   function automatic logic [DATA_W-1:0] gen_mask(input int idx);
      if (idx == GEN_LIN || idx == GEN_STEP) begin
         return 32'h0000_0001;
      end else begin
         return 32'h0000_ffff;
      end
   endfunction

   // ------------------------------------------------------------------
   // Settings, conversion-constant banks and saved defaults
   // ------------------------------------------------------------------
   // Storage is plain flops indexed by setting number.
   logic [DATA_W-1:0] gen_q     [GEN_N];
   logic [DATA_W-1:0] gen_d     [GEN_N];
   logic [DATA_W-1:0] def_gen_q [GEN_N];
   logic [DATA_W-1:0] def_gen_d [GEN_N];
   logic [DATA_W-1:0] plk_q     [GAIN_N][PLK_N];
   logic [DATA_W-1:0] plk_d     [GAIN_N][PLK_N];
   logic [DATA_W-1:0] def_plk_q [GAIN_N][PLK_N];
   logic [DATA_W-1:0] def_plk_d [GAIN_N][PLK_N];
   logic              saved_q;
   logic              saved_d;
   logic              gain_q;
   logic              gain_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   // Decode once per access; both the write and read paths use it.
   int  wr_gen;
   int  wr_plk;
   int  rd_gen;
   int  rd_plk;
   logic do_save;
   logic do_restore;

   // Reads and writes share one decode, since the bus never raises both
   // strobes in the same cycle.
   assign wr_gen     = gen_sel(reg_addr);
   assign wr_plk     = plk_sel(reg_addr);
   assign rd_gen     = wr_gen;
   assign rd_plk     = wr_plk;
   assign do_save    = reg_write && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_SAVE_BIT];
   assign do_restore = reg_write && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_RESTORE_BIT];

   // Register writes, the save command and the restore command. A restore
   // reloads the saved defaults, so a change not saved does not survive it.
   // Save wins over restore when both bits are written at once.
   always_comb begin
      gen_d     = gen_q;
      plk_d     = plk_q;
      def_gen_d = def_gen_q;
      def_plk_d = def_plk_q;
      saved_d   = saved_q;
      gain_d    = gain_high;
      if (do_save) begin
         def_gen_d = gen_q;
         def_plk_d = plk_q;
         saved_d   = 1'b1;
      end else if (do_restore) begin
         gen_d = def_gen_q;
         plk_d = def_plk_q;
      end else if (reg_write && wr_gen >= 0) begin
         gen_d[wr_gen] = reg_wdata & gen_mask(wr_gen);
      end else if (reg_write && wr_plk >= 0) begin
         // Writes land in the bank of the gain mode now in use.
         plk_d[gain_q][wr_plk] = reg_wdata;
         if (wr_plk == PLK_OFLT && reg_wdata[FLOAT_SIGN_BIT]) begin
            plk_d[gain_q][wr_plk] = 32'h0000_0000;
         end
      end
   end

   // Flops for every setting group; reset loads the power-on values.
   // The saved copy is held in flops too, so it lasts only until reset.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gen_q     <= GEN_RESET;
         def_gen_q <= GEN_RESET;
         plk_q     <= PLK_RESET;
         def_plk_q <= PLK_RESET;
         saved_q   <= 1'b0;
         gain_q    <= 1'b0;
      end else begin
         gen_q     <= gen_d;
         def_gen_q <= def_gen_d;
         plk_q     <= plk_d;
         def_plk_q <= def_plk_d;
         saved_q   <= saved_d;
         gain_q    <= gain_d;
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------

   // The constant registers show the bank of the current gain mode, so a
   // gain switch swaps in the whole matching set in a single cycle.
   // Unmapped reads and idle cycles both give zero, so a stale word can
   // never be mistaken for a fresh answer.
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (reg_read) begin
         if (rd_gen >= 0) begin
            rdata_d = gen_q[rd_gen];
         end else if (rd_plk >= 0) begin
            rdata_d = plk_q[gain_q][rd_plk];
         end else if (reg_addr == OFS_COMMAND) begin
            rdata_d[STAT_GAIN_BIT]  = gain_q;
            rdata_d[STAT_SAVED_BIT] = saved_q;
         end
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // The read port is the registered word itself.
   assign reg_rdata = rdata_q;

   // ------------------------------------------------------------------
   // Pixel datapath
   // ------------------------------------------------------------------
   logic        corr_valid;
   logic [16:0] corr_kelvin;
   logic [13:0] corr_signal;

   // Object correction forms the first stage. It reads the object
   // parameters as they stand when a pixel enters, so one pixel never
   // mixes old and new values. Its enable follows linear mode, because
   // the corrections have no meaning for the signal passed through.
   object_correct u_object_correct (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .enable       (gen_q[GEN_LIN][0]),
      .in_valid     (pix_valid),
      .in_kelvin    (pix_kelvin),
      .in_signal    (pix_signal),
      .reflect_k    (gen_q[GEN_REFL][15:0]),
      .emissivity   (gen_q[GEN_EMIS][15:0]),
      .window_pass  (gen_q[GEN_WPASS][15:0]),
      .window_k     (gen_q[GEN_WK][15:0]),
      .air_pass     (gen_q[GEN_APASS][15:0]),
      .air_k        (gen_q[GEN_AK][15:0]),
      .out_valid_q  (corr_valid),
      .out_kelvin_q (corr_kelvin),
      .out_signal_q (corr_signal)
   );

   logic        out_valid_q;
   logic        out_valid_d;
   logic [15:0] out_pix_q;
   logic [15:0] out_pix_d;
   logic        out_lin_q;
   logic        out_lin_d;

   // Linear enable and step select are read here, one stage after entry.
   // Kelvin arrives in 0.04 K counts. The coarse step divides by ten with
   // a reciprocal multiply, exact for every 16-bit count, which avoids a
   // real divider. Counts beyond 14 bits saturate rather than wrap.
   always_comb begin
      logic [32:0] prod;
      logic [16:0] counts;
      prod   = 33'({16'h0000, corr_kelvin} * {17'h00000, DIV10_MUL});
      counts = corr_kelvin;
      if (!gen_q[GEN_STEP][0]) begin
         counts = 17'(prod >> DIV10_SHIFT);
      end
      out_valid_d = corr_valid;
      out_lin_d   = gen_q[GEN_LIN][0];
      if (gen_q[GEN_LIN][0]) begin
         if (counts > 17'({3'b000, PIX_MAX})) begin
            out_pix_d = {2'b00, PIX_MAX};
         end else begin
            out_pix_d = {2'b00, counts[PIX_W-1:0]};
         end
      end else begin
         out_pix_d = {2'b00, corr_signal};
      end
   end

   // Output stage. Every pixel output leaves straight from a flop, which
   // gives the stream packer a full cycle of timing margin.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         out_valid_q <= 1'b0;
         out_pix_q   <= 16'h0000;
         out_lin_q   <= 1'b0;
      end else begin
         out_valid_q <= out_valid_d;
         out_pix_q   <= out_pix_d;
         out_lin_q   <= out_lin_d;
      end
   end

   // Top-level pixel outputs.
   assign pix_out_valid  = out_valid_q;
   assign pix_out        = out_pix_q;
   assign pix_out_linear = out_lin_q;

endmodule

// [verif/thermal_pixel_map_checker.sv]
`timescale 1ns/1ps
module thermal_pixel_map_checker
   import thermal_map_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_write,
   input wire logic              reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              gain_high,
   input wire logic              pix_valid,
   input wire logic [13:0]       pix_signal,
   input wire logic [15:0]       pix_kelvin,
   input wire logic              pix_out_valid,
   input wire logic [15:0]       pix_out,
   input wire logic              pix_out_linear
);
   // ------------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------------
   // One clock domain, so clocking and reset are declared once.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // A write followed at once by a read of the same place, gain held still.
   sequence s_wr_rd(logic [7:0] a);
      (reg_write && reg_addr == a && $stable(gain_high))
      ##1 (reg_read && reg_addr == a && $stable(gain_high));
   endsequence

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   property p_out_lat;
      pix_valid |-> ##2 pix_out_valid;
   endproperty
   property p_out_cause;
      pix_out_valid |-> $past(pix_valid, 2);
   endproperty
   property p_upper_zero;
      pix_out_valid |-> pix_out[15:14] == 2'b00;
   endproperty
   property p_passthrough;
      pix_out_valid && !pix_out_linear |-> pix_out == {2'b00, $past(pix_signal, 2)};
   endproperty
   property p_enable_back;
      s_wr_rd(OFS_LINEAR_ENABLE) |=> reg_rdata[0] == $past(reg_wdata[0], 2);
   endproperty
   property p_signed_back;
      s_wr_rd(OFS_OFFSET_SIGNED) or s_wr_rd(OFS_SCALE_INT) |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   property p_float_clamp;
      s_wr_rd(OFS_OFFSET_FLOAT) ##0 $past(reg_wdata[FLOAT_SIGN_BIT]) |=> reg_rdata == '0;
   endproperty
   property p_gain_status;
      $stable(gain_high)[*3] ##0 (reg_read && reg_addr == OFS_COMMAND)
      |=> reg_rdata[STAT_GAIN_BIT] == $past(gain_high);
   endproperty
   property p_rdata_idle;
      !reg_read |=> reg_rdata == '0;
   endproperty
   property p_unmapped;
      reg_read && reg_addr > OFS_COMMAND |=> reg_rdata == '0;
   endproperty

   a_out_lat: assert property (p_out_lat) else $error("output pixel late or missing");
   a_out_cause: assert property (p_out_cause) else $error("output pixel without input");
   a_upper_zero: assert property (p_upper_zero) else $error("upper pixel bits set");
   a_passthrough: assert property (p_passthrough) else $error("signal not passed");
   a_enable_back: assert property (p_enable_back) else $error("enable readback wrong");
   a_signed_back: assert property (p_signed_back) else $error("constant readback wrong");
   a_float_clamp: assert property (p_float_clamp) else $error("negative float kept");
   a_gain_status: assert property (p_gain_status) else $error("gain status wrong");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind thermal_pixel_map thermal_pixel_map_checker chk (
   .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .gain_high(gain_high),
   .pix_valid(pix_valid), .pix_signal(pix_signal), .pix_kelvin(pix_kelvin),
   .pix_out_valid(pix_out_valid), .pix_out(pix_out), .pix_out_linear(pix_out_linear));

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench
   import thermal_map_pkg::*;
   ;
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_write = 1'b0;
   logic              reg_read = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic              gain_high = 1'b0;
   logic              pix_valid = 1'b0;
   logic [13:0]       pix_signal = '0;
   logic [15:0]       pix_kelvin = '0;
   logic              pix_out_valid;
   logic [15:0]       pix_out;
   logic              pix_out_linear;
   int                err_count = 0;
   int                checked = 0;

   // Free-running 50 MHz clock.
   always #10 sys_clk = ~sys_clk;

   thermal_pixel_map dut (
      .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .gain_high(gain_high), .pix_valid(pix_valid), .pix_signal(pix_signal),
      .pix_kelvin(pix_kelvin), .pix_out_valid(pix_out_valid), .pix_out(pix_out),
      .pix_out_linear(pix_out_linear));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic finish_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Strobes are left up so that back-to-back accesses need no gap cycle.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_write <= 1'b1;
      reg_read <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
      reg_read <= 1'b1;
      reg_write <= 1'b0;
      reg_addr <= a;
      @(posedge sys_clk);
      #1;
      chk(name, reg_rdata, e);
   endtask

   task automatic idle(input int n);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
      end
   endtask

   // The wait is bounded; the checker holds the exact latency.
   task automatic pix(input logic [13:0] s, input logic [15:0] k, input logic [15:0] e,
                      input logic l);
      int i;
      idle(0);
      pix_valid <= 1'b1;
      pix_signal <= s;
      pix_kelvin <= k;
      @(posedge sys_clk);
      #1;
      pix_valid <= 1'b0;
      for (i = 0; i < 4 && pix_out_valid !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      if (pix_out_valid !== 1'b1) begin
         err_count++;
         $display("MISMATCH pix_out_valid expected 1 seen %b", pix_out_valid);
         finish_test();
      end else begin
         chk("pix_out", {16'h0, pix_out}, {16'h0, e});
         chk("pix_out_linear", {31'h0, pix_out_linear}, {31'h0, l});
      end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      int a;
      for (a = 0; a <= OFS_COMMAND; a += 4) begin
         rd_chk("reset_value", 8'(a), (a == OFS_EMISSIVITY || a == OFS_WINDOW_PASS ||
                a == OFS_AIR_PASS) ? 32'h0000_8000 : 32'h0);
      end
      rd_chk("unmapped", 8'h40, 32'h0);
      rd_chk("window_pass", OFS_WINDOW_PASS, 32'h0000_8000);
      idle(1);
      chk("rdata_idle", reg_rdata, 32'h0);
   endtask

   task automatic t_linear();
      wr(OFS_LINEAR_ENABLE, 32'h1);
      rd_chk("enable", OFS_LINEAR_ENABLE, 32'h1);
      wr(OFS_STEP_SELECT, 32'h1);
      pix(14'h0123, 16'd7500, 16'd7500, 1'b1);
      pix(14'h0123, 16'hffff, 16'h3fff, 1'b1);
      wr(OFS_STEP_SELECT, 32'h0);
      pix(14'h0123, 16'd7500, 16'd750, 1'b1);
      pix(14'h0123, 16'd7509, 16'd750, 1'b1);
      wr(OFS_LINEAR_ENABLE, 32'h0);
      pix(14'h2abc, 16'd7500, 16'h2abc, 1'b0);
   endtask

   // Half emissivity with a cold background lifts the target by half.
   task automatic t_object();
      wr(OFS_EMISSIVITY, 32'h4000);
      pix(14'h0456, 16'd1000, 16'h0456, 1'b0);
      wr(OFS_LINEAR_ENABLE, 32'h1);
      wr(OFS_STEP_SELECT, 32'h1);
      pix(14'h0456, 16'd1000, 16'd1500, 1'b1);
      wr(OFS_REFLECT_K, 32'd200);
      pix(14'h0456, 16'd1000, 16'd1400, 1'b1);
      wr(OFS_EMISSIVITY, 32'h8000);
      pix(14'h0456, 16'd1000, 16'd1000, 1'b1);
      wr(OFS_WINDOW_PASS, 32'h4000);
      wr(OFS_WINDOW_K, 32'd600);
      wr(OFS_AIR_PASS, 32'h4000);
      wr(OFS_AIR_K, 32'd1200);
      pix(14'h0456, 16'd1000, 16'd1100, 1'b1);
   endtask

   task automatic t_bank();
      wr(OFS_SCALE_INT, 32'h11);
      rd_chk("scale_low", OFS_SCALE_INT, 32'h11);
      gain_high <= 1'b1;
      idle(3);
      rd_chk("status_high", OFS_COMMAND, 32'h1);
      rd_chk("scale_high", OFS_SCALE_INT, 32'h0);
      wr(OFS_SCALE_INT, 32'h22);
      rd_chk("scale_high_wr", OFS_SCALE_INT, 32'h22);
      gain_high <= 1'b0;
      idle(3);
      rd_chk("scale_low_back", OFS_SCALE_INT, 32'h11);
      wr(OFS_OFFSET_FLOAT, 32'h8000_0001);
      rd_chk("offset_neg", OFS_OFFSET_FLOAT, 32'h0);
      wr(OFS_OFFSET_FLOAT, 32'h3f80_0000);
      rd_chk("offset_pos", OFS_OFFSET_FLOAT, 32'h3f80_0000);
      wr(OFS_OFFSET_SIGNED, 32'hffff_fff0);
      rd_chk("offset_signed", OFS_OFFSET_SIGNED, 32'hffff_fff0);
      wr(OFS_NUMERATOR, 32'h4496_6000);
      rd_chk("numerator", OFS_NUMERATOR, 32'h4496_6000);
      wr(OFS_ADDITIVE, 32'h3f80_0000);
      rd_chk("additive", OFS_ADDITIVE, 32'h3f80_0000);
   endtask

   // Defaults live in flops, so a reset wipes the saved copy as well.
   task automatic t_save();
      wr(OFS_COMMAND, 32'h1 << CMD_SAVE_BIT);
      rd_chk("status_saved", OFS_COMMAND, 32'h2);
      wr(OFS_OFFSET_SIGNED, 32'h5);
      rd_chk("offset_changed", OFS_OFFSET_SIGNED, 32'h5);
      wr(OFS_COMMAND, 32'h1 << CMD_RESTORE_BIT);
      idle(1);
      rd_chk("offset_restored", OFS_OFFSET_SIGNED, 32'hffff_fff0);
      rd_chk("enable_restored", OFS_LINEAR_ENABLE, 32'h1);
      idle(1);
      resetn <= 1'b0;
      idle(2);
      resetn <= 1'b1;
      rd_chk("offset_after_reset", OFS_OFFSET_SIGNED, 32'h0);
   endtask

   // Reset for four cycles, then every scenario in turn.
   initial begin
      repeat (4) @(posedge sys_clk);
      #1;
      resetn <= 1'b1;
      t_reset();
      t_linear();
      t_object();
      t_bank();
      t_save();
      idle(2);
      finish_test();
   end
endmodule
